//--- core/iofpu_pkg.sv
/*
 package for the io function parameter block: parameter offsets,
 table indices, function codes, factory values and carrier structs.
 assumes one 20 MHz clock domain shared by all users.
*/
package iofpu_pkg;
   localparam int AW = 12;
   localparam int NPAR = 22;
   // parameter offsets
   localparam logic [11:0] OFS_IN_FUNC0 = 12'h840;
   localparam logic [11:0] OFS_IN_LOGIC0 = 12'h850;
   localparam logic [11:0] OFS_OUT_FUNC0 = 12'h860;
   localparam logic [11:0] OFS_OUT_LOGIC0 = 12'h870;
   localparam logic [11:0] OFS_PANEL_EDIT = 12'h1E8;
   localparam logic [11:0] OFS_INIT_VIEW = 12'h1E9;
   localparam logic [11:0] OFS_B_SLOT = 12'h0F0;
   localparam logic [11:0] OFS_D_SLOT = 12'h0F1;
   localparam logic [11:0] OFS_CONFIG = 12'h0F8;
   localparam logic [11:0] OFS_STATUS = 12'h0F9;
   // table indices
   localparam logic [4:0] IDX_IN_LOGIC0 = 5'h07;
   localparam logic [4:0] IDX_OUT_FUNC0 = 5'h0E;
   localparam logic [4:0] IDX_OUT_LOGIC0 = 5'h10;
   localparam logic [4:0] IDX_PANEL_EDIT = 5'h12;
   localparam logic [4:0] IDX_INIT_VIEW = 5'h13;
   localparam logic [4:0] IDX_B_SLOT = 5'h14;
   localparam logic [4:0] IDX_D_SLOT = 5'h15;
   localparam logic [4:0] IDX_NONE = 5'h1F;
   // input function codes
   localparam logic [7:0] IN_UNUSED = 8'h00;
   localparam logic [7:0] IN_FAULT_CLR = 8'h08;
   localparam logic [7:0] IN_NOTICE_CLR = 8'h0E;
   localparam logic [7:0] IN_PANEL_LOCK = 8'h10;
   localparam logic [7:0] IN_TORQUE_LIM = 8'h16;
   localparam logic [7:0] IN_OUT_FAULT = 8'h19;
   localparam logic [7:0] IN_FWD_RUN = 8'h3A;
   localparam logic [7:0] IN_BWD_RUN = 8'h3B;
   localparam logic [7:0] IN_SEL_BIT0 = 8'h40;
   localparam logic [7:0] IN_HALT_STYLE = 8'h48;
   localparam logic [7:0] IN_BRAKE_REL = 8'h49;
   localparam logic [7:0] IN_FREE_REL = 8'h4A;
   // output function codes
   localparam logic [7:0] OUT_FAULT = 8'h82;
   localparam logic [7:0] OUT_MOVING = 8'h86;
   localparam logic [7:0] OUT_NOTICE = 8'h87;
   localparam logic [7:0] OUT_TORQUE_CAP = 8'h8C;
   localparam logic [7:0] OUT_SPEED_HIT = 8'h8D;
   localparam logic [7:0] OUT_SPEED_PULSE = 8'h93;
   localparam logic [7:0] OUT_ROT_SENSE = 8'h94;
   localparam logic [7:0] VIEW_MAX = 8'h02;
   localparam logic [7:0] PANEL_EDIT_DEF = 8'h01;
   // factory function codes of input lines 0..6, line 0 in the low byte
   localparam logic [55:0] IN_FUNC_DEF = 56'h49_08_41_40_48_3B_3A;
   localparam logic [15:0] OUT_FUNC_DEF = 16'h82_93;
   // status bits
   localparam int ST_PEND_B = 0;
   localparam int ST_PEND_C = 1;
   localparam int ST_PEND_D = 2;
   localparam int ST_REFUSED = 3;
   typedef enum logic [1:0] {UPD_A, UPD_B, UPD_C, UPD_D} iofpu_cls_t;
   typedef struct packed {
      logic fault_clear;
      logic notice_clear;
      logic panel_lock;
      logic torque_limit;
      logic outside_fault;
      logic forward_run;
      logic backward_run;
      logic halt_style;
      logic [3:0] data_select;
      logic brake_release;
      logic free_release;
   } iofpu_in_fn_t;
   typedef struct packed {
      logic fault;
      logic moving;
      logic notice;
      logic torque_capped;
      logic speed_reached;
      logic speed_pulse;
      logic rot_sense;
   } iofpu_out_src_t;
endpackage

//--- core/iofpu_core.sv
/*
 io function parameter block: stored and active parameter copies,
 update classes, input and output line function mapping.
 assumes a synchronous register port, rst_i as the power cycle and
 nv_fresh_i high when the non-volatile store holds no valid data.
*/
`timescale 1ns/10ps
module iofpu_core import iofpu_pkg::*; #(
   parameter bit BRAKE_VARIANT = 1'b1
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [AW-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // drive state
   input wire logic nv_fresh_i,
   input wire logic motor_run_i,
   input wire iofpu_out_src_t out_src_i,
   // lines
   input wire logic [6:0] in_line_i,
   output logic [1:0] out_line_o,
   output iofpu_in_fn_t in_fn_o,
   // panel
   output logic [1:0] panel_view_o,
   output logic panel_edit_o
);
   typedef enum {ST_BOOT, ST_RUN} iofpu_st_t;

   function automatic logic [4:0] par_index(input logic [AW-1:0] a);
      logic [AW-1:0] d;
      d = a - OFS_IN_FUNC0;
      if (a >= OFS_IN_FUNC0 && a <= OFS_IN_FUNC0 + 12'h006) return d[4:0];
      d = a - OFS_IN_LOGIC0;
      if (a >= OFS_IN_LOGIC0 && a <= OFS_IN_LOGIC0 + 12'h006) return 5'(IDX_IN_LOGIC0 + d[4:0]);
      d = a - OFS_OUT_FUNC0;
      if (a >= OFS_OUT_FUNC0 && a <= OFS_OUT_FUNC0 + 12'h001) return 5'(IDX_OUT_FUNC0 + d[4:0]);
      d = a - OFS_OUT_LOGIC0;
      if (a >= OFS_OUT_LOGIC0 && a <= OFS_OUT_LOGIC0 + 12'h001)
         return 5'(IDX_OUT_LOGIC0 + d[4:0]);
      if (a == OFS_PANEL_EDIT) return IDX_PANEL_EDIT;
      if (a == OFS_INIT_VIEW) return IDX_INIT_VIEW;
      if (a == OFS_B_SLOT) return IDX_B_SLOT;
      if (a == OFS_D_SLOT) return IDX_D_SLOT;
      return IDX_NONE;
   endfunction

   function automatic iofpu_cls_t par_class(input int i);
      if (i == int'(IDX_PANEL_EDIT) || i == int'(IDX_INIT_VIEW)) return UPD_A;
      if (i == int'(IDX_B_SLOT)) return UPD_B;
      if (i == int'(IDX_D_SLOT)) return UPD_D;
      return UPD_C;
   endfunction

   function automatic logic [7:0] par_default(input int i);
      if (i < int'(IDX_IN_LOGIC0)) return IN_FUNC_DEF[i*8 +: 8];
      if (i == int'(IDX_OUT_FUNC0)) return OUT_FUNC_DEF[7:0];
      if (i == int'(IDX_OUT_FUNC0) + 1) return OUT_FUNC_DEF[15:8];
      if (i == int'(IDX_PANEL_EDIT)) return PANEL_EDIT_DEF;
      return 8'h00;
   endfunction

   function automatic logic par_valid(input logic [4:0] i, input logic [7:0] v);
      if (i < IDX_IN_LOGIC0)
         return v == IN_UNUSED || v == IN_FAULT_CLR || v == IN_NOTICE_CLR ||
            v == IN_PANEL_LOCK || v == IN_TORQUE_LIM || v == IN_OUT_FAULT ||
            v == IN_FWD_RUN || v == IN_BWD_RUN || v == IN_HALT_STYLE ||
            (v >= IN_SEL_BIT0 && v <= IN_SEL_BIT0 + 8'h03) || v == IN_FREE_REL ||
            (v == IN_BRAKE_REL && BRAKE_VARIANT);
      if (i == IDX_OUT_FUNC0 || i == IDX_OUT_FUNC0 + 5'h01)
         return v == 8'h00 || v == OUT_FAULT || v == OUT_MOVING || v == OUT_NOTICE ||
            v == OUT_TORQUE_CAP || v == OUT_SPEED_HIT || v == OUT_SPEED_PULSE ||
            v == OUT_ROT_SENSE;
      if (i == IDX_INIT_VIEW) return v <= VIEW_MAX;
      if (i == IDX_B_SLOT || i == IDX_D_SLOT) return 1'b1;
      return v <= 8'h01;
   endfunction

   // any line whose active code matches c and whose level is asserted
   function automatic logic any_line(input logic [6:0] lvl, input logic [6:0][7:0] cd,
      input logic [7:0] c);
      logic h;
      h = 1'b0;
      for (int l = 0; l < 7; l++) h = h | (lvl[l] & (cd[l] == c));
      return h;
   endfunction

   function automatic logic out_pick(input iofpu_out_src_t s, input logic [7:0] c);
      unique case (c)
         OUT_FAULT: return s.fault;
         OUT_MOVING: return s.moving;
         OUT_NOTICE: return s.notice;
         OUT_TORQUE_CAP: return s.torque_capped;
         OUT_SPEED_HIT: return s.speed_reached;
         OUT_SPEED_PULSE: return s.speed_pulse;
         OUT_ROT_SENSE: return s.rot_sense;
         default: return 1'b0;
      endcase
   endfunction

   iofpu_st_t st_r;
   logic [NPAR-1:0][7:0] active_r;
   logic [7:0] nv_mem [NPAR];
   logic pend_b_r, pend_c_r, pend_d_r, refused_r;
   logic [7:0] status_w;

   // register port decode
   wire run_w = (st_r == ST_RUN);
   wire [4:0] wr_idx = par_index(addr_i);
   wire wr_hit = wr_i && run_w && (wr_idx != IDX_NONE);
   wire wr_ok = wr_hit && par_valid(wr_idx, wdata_i);
   wire cfg_cmd = wr_i && run_w && (addr_i == OFS_CONFIG);
   wire [4:0] rd_idx = par_index(addr_i);
   wire cls_b_wr = wr_ok && par_class(int'(wr_idx)) == UPD_B;
   wire cls_c_wr = wr_ok && par_class(int'(wr_idx)) == UPD_C;
   wire cls_d_wr = wr_ok && par_class(int'(wr_idx)) == UPD_D;
   wire b_apply = run_w && pend_b_r && !motor_run_i;

   assign status_w = {4'h0, refused_r, pend_d_r, pend_c_r, pend_b_r};

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= ST_BOOT;
      end else begin
         st_r <= ST_RUN;
      end
   end

   // the store has no reset: it stands for memory that outlives power
   always_ff @(posedge ref_clk_i) begin
      for (int i = 0; i < NPAR; i++) begin
         if (!run_w && nv_fresh_i) begin
            nv_mem[i] <= par_default(i);
         end else if (wr_ok && int'(wr_idx) == i) begin
            nv_mem[i] <= wdata_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < NPAR; i++) active_r[i] <= par_default(i);
      end else if (!run_w) begin
         for (int i = 0; i < NPAR; i++)
            active_r[i] <= nv_fresh_i ? par_default(i) : nv_mem[i];
      end else begin
         for (int i = 0; i < NPAR; i++) begin
            unique case (par_class(i))
               UPD_A: if (wr_ok && int'(wr_idx) == i) active_r[i] <= wdata_i;
               UPD_B: if (b_apply) active_r[i] <= nv_mem[i];
               UPD_C: if (cfg_cmd) active_r[i] <= nv_mem[i];
               UPD_D: active_r[i] <= active_r[i];
            endcase
         end
      end
   end

   // pending flags: a new write wins over the apply that clears it
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_b_r <= 1'b0;
         pend_c_r <= 1'b0;
         pend_d_r <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         pend_b_r <= cls_b_wr || (pend_b_r && !b_apply);
         pend_c_r <= cls_c_wr || (pend_c_r && !cfg_cmd);
         pend_d_r <= cls_d_wr || pend_d_r;
         if (wr_hit) refused_r <= !wr_ok;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i && rd_idx != IDX_NONE) begin
         rdata_o <= nv_mem[rd_idx];
      end else if (rd_i && addr_i == OFS_STATUS) begin
         rdata_o <= status_w;
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // input lines: inversion then function decode
   logic [6:0] ln_lvl;
   logic [6:0][7:0] ln_code;
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_in
         assign ln_lvl[g] = in_line_i[g] ^ active_r[int'(IDX_IN_LOGIC0) + g][0];
         assign ln_code[g] = active_r[g];
      end
   endgenerate

   iofpu_in_fn_t fn_nxt;
   assign fn_nxt.fault_clear = any_line(ln_lvl, ln_code, IN_FAULT_CLR);
   assign fn_nxt.notice_clear = any_line(ln_lvl, ln_code, IN_NOTICE_CLR);
   assign fn_nxt.panel_lock = any_line(ln_lvl, ln_code, IN_PANEL_LOCK);
   assign fn_nxt.torque_limit = any_line(ln_lvl, ln_code, IN_TORQUE_LIM);
   assign fn_nxt.outside_fault = any_line(ln_lvl, ln_code, IN_OUT_FAULT);
   assign fn_nxt.forward_run = any_line(ln_lvl, ln_code, IN_FWD_RUN);
   assign fn_nxt.backward_run = any_line(ln_lvl, ln_code, IN_BWD_RUN);
   assign fn_nxt.halt_style = any_line(ln_lvl, ln_code, IN_HALT_STYLE);
   generate
      for (g = 0; g < 4; g++) begin : g_sel
         assign fn_nxt.data_select[g] =
            any_line(ln_lvl, ln_code, 8'(IN_SEL_BIT0 + g));
      end
   endgenerate
   assign fn_nxt.brake_release =
      BRAKE_VARIANT && any_line(ln_lvl, ln_code, IN_BRAKE_REL);
   assign fn_nxt.free_release = any_line(ln_lvl, ln_code, IN_FREE_REL);

   logic [1:0] out_nxt;
   generate
      for (g = 0; g < 2; g++) begin : g_out
         assign out_nxt[g] = out_pick(out_src_i, active_r[int'(IDX_OUT_FUNC0) + g]) ^
            active_r[int'(IDX_OUT_LOGIC0) + g][0];
      end
   endgenerate

   // lines stay idle while the boot copy settles
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         in_fn_o <= '0;
         out_line_o <= 2'h0;
      end else begin
         in_fn_o <= run_w ? fn_nxt : '0;
         out_line_o <= run_w ? out_nxt : 2'h0;
      end
   end

   assign panel_view_o = active_r[IDX_INIT_VIEW][1:0];
   assign panel_edit_o = active_r[IDX_PANEL_EDIT][0];

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_b_write;
      wr_ok && wr_idx == IDX_B_SLOT;
   endsequence
   sequence s_stopped_quiet;
      (!motor_run_i && !wr_i) [*2];
   endsequence

   AST_IN_FAULT: assert property (run_w && ln_code[5] == IN_FAULT_CLR && ln_lvl[5]
      |=> in_fn_o.fault_clear) else $error("fault clear line not mapped");
   AST_IN_RUN: assert property (run_w && ln_code[0] == IN_FWD_RUN
      |=> in_fn_o.forward_run == $past(ln_lvl[0]) || $past(ln_code[1] == IN_FWD_RUN))
      else $error("forward run not following line 0");
   AST_IN_SEL: assert property (run_w && ln_code[0] == 8'h43 && ln_lvl[0]
      |=> in_fn_o.data_select[3]) else $error("select bit 3 missing");
   AST_IN_FREE: assert property (run_w && ln_code[0] == IN_FREE_REL && ln_lvl[0]
      |=> in_fn_o.free_release) else $error("free release missing");
   AST_NO_BRAKE: assert property (!BRAKE_VARIANT |-> !in_fn_o.brake_release)
      else $error("brake release on plain variant");
   AST_FACTORY: assert property (!run_w && nv_fresh_i
      |=> active_r[0] == IN_FWD_RUN && active_r[5] == IN_FAULT_CLR &&
      active_r[6] == IN_BRAKE_REL) else $error("factory input codes wrong");
   AST_LOGIC_HOLD: assert property (run_w && !cfg_cmd
      |=> $stable(active_r[IDX_IN_LOGIC0])) else $error("inversion changed early");
   AST_OUT_LINE: assert property (run_w && active_r[IDX_OUT_FUNC0] == OUT_MOVING
      |=> out_line_o[0] == ($past(out_src_i.moving) ^ $past(active_r[IDX_OUT_LOGIC0][0])))
      else $error("output 0 not showing moving");
   AST_OUT_FACT: assert property (!run_w && nv_fresh_i
      |=> active_r[IDX_OUT_FUNC0] == OUT_SPEED_PULSE && active_r[15] == OUT_FAULT)
      else $error("factory output codes wrong");
   AST_VIEW_NOW: assert property (wr_ok && wr_idx == IDX_INIT_VIEW
      |=> panel_view_o == $past(wdata_i[1:0])) else $error("view not immediate");
   AST_NV_KEEP: assert property (wr_ok
      |=> nv_mem[$past(wr_idx)] == $past(wdata_i)) else $error("write not stored");
   AST_B_WAIT: assert property (run_w && motor_run_i
      |=> $stable(active_r[IDX_B_SLOT])) else $error("class B applied while moving");
   AST_B_APPLY: assert property (s_b_write ##1 s_stopped_quiet
      |-> active_r[IDX_B_SLOT] == nv_mem[IDX_B_SLOT]) else $error("class B not applied");
   AST_C_APPLY: assert property (cfg_cmd
      |=> active_r[0] == $past(nv_mem[0])) else $error("class C not applied");
   AST_D_HOLD: assert property (run_w |=> $stable(active_r[IDX_D_SLOT]))
      else $error("class D changed while running");
endmodule

//--- verif/iofpu_ext_ctrl.sv
/*
 outside controller model: drives the seven general input lines and
 the drive state sources that feed the two output lines.
 assumes the bench sets the wanted levels; they reach the block one
 clock later, registered, as from a synchronous controller.
*/
`timescale 1ns/10ps
module iofpu_ext_ctrl import iofpu_pkg::*; (
   // clock
   input wire logic ref_clk_i,
   // levels wanted by the bench
   input wire logic [6:0] lvl_i,
   input wire iofpu_out_src_t src_i,
   // lines toward the block
   output logic [6:0] in_line_o,
   output iofpu_out_src_t out_src_o
);
   // lines change only just after an edge, so the block never sees a change at its sampling edge
   always_ff @(posedge ref_clk_i) begin
      in_line_o <= lvl_i;
      out_src_o <= src_i;
   end
endmodule

//--- verif/tb_io_function_param_update.sv
/*
 testbench of the io function parameter block: register access tasks,
 factory values, line mapping, inversion and update classes.
 assumes rst_i stands for a power cycle and the store survives it.
*/
`timescale 1ns/10ps
module tb_io_function_param_update import iofpu_pkg::*;;
   logic ref_clk_i, rst_i, wr_i, rd_i, nv_fresh_i, motor_run_i, panel_edit_o;
   logic [AW-1:0] addr_i;
   logic [7:0] wdata_i, rdata_o, rv;
   logic [6:0] lvl, in_line_i;
   logic [1:0] out_line_o, panel_view_o;
   iofpu_out_src_t src, out_src_i;
   iofpu_in_fn_t in_fn_o;
   int miscompares, checked;
   logic [7:0] in_codes [15] = '{8'h00, 8'h08, 8'h0E, 8'h10, 8'h16, 8'h19, 8'h3A, 8'h3B,
      8'h40, 8'h41, 8'h42, 8'h43, 8'h48, 8'h49, 8'h4A};
   logic [7:0] out_codes [8] = '{8'h00, 8'h82, 8'h86, 8'h87, 8'h8C, 8'h8D, 8'h93, 8'h94};
   logic [6:0] out_oh [8] = '{7'h7F, 7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};

   iofpu_core #(.BRAKE_VARIANT(1'b1)) uut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nv_fresh_i(nv_fresh_i),
      .motor_run_i(motor_run_i), .out_src_i(out_src_i), .in_line_i(in_line_i),
      .out_line_o(out_line_o), .in_fn_o(in_fn_o), .panel_view_o(panel_view_o),
      .panel_edit_o(panel_edit_o));
   iofpu_ext_ctrl partner (.ref_clk_i(ref_clk_i), .lvl_i(lvl), .src_i(src),
      .in_line_o(in_line_i), .out_src_o(out_src_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   // function expected on the lines when only one line with this code is active
   function automatic iofpu_in_fn_t exp_fn(input logic [7:0] c);
      iofpu_in_fn_t f;
      f = '0;
      case (c)
         8'h08: f.fault_clear = 1'b1;
         8'h0E: f.notice_clear = 1'b1;
         8'h10: f.panel_lock = 1'b1;
         8'h16: f.torque_limit = 1'b1;
         8'h19: f.outside_fault = 1'b1;
         8'h3A: f.forward_run = 1'b1;
         8'h3B: f.backward_run = 1'b1;
         8'h40, 8'h41, 8'h42, 8'h43: f.data_select[c[1:0]] = 1'b1;
         8'h48: f.halt_style = 1'b1;
         8'h49: f.brake_release = 1'b1;
         8'h4A: f.free_release = 1'b1;
         default: f = '0;
      endcase
      return f;
   endfunction

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", n, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [11:0] a, input logic [7:0] exp, input string n);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      rv = rdata_o;
      chk(n, 32'(rv), 32'(exp));
   endtask

   // partner register, block register, one spare edge
   task automatic settle;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic cfg;
      wr(OFS_CONFIG, 8'h00);
      settle;
   endtask

   task automatic power_cycle(input logic fresh);
      @(posedge ref_clk_i);
      nv_fresh_i <= fresh;
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      miscompares++;
      stop_test;
   end

   initial begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = '0;
      wdata_i = '0;
      nv_fresh_i = 1'b1;
      motor_run_i = 1'b0;
      lvl = '0;
      src = '0;
      power_cycle(1'b1);
      for (int i = 0; i < 7; i++) begin
         rchk(OFS_IN_FUNC0 + 12'(i), IN_FUNC_DEF[8*i +: 8], "in_func");
         rchk(OFS_IN_LOGIC0 + 12'(i), 8'h00, "in_logic");
         lvl <= 7'(1) << i;
         settle;
         chk("in_fn_factory", 32'(in_fn_o), 32'(exp_fn(IN_FUNC_DEF[8*i +: 8])));
      end
      rchk(OFS_OUT_FUNC0, OUT_FUNC_DEF[7:0], "out_func0");
      rchk(OFS_OUT_FUNC0 + 12'h001, OUT_FUNC_DEF[15:8], "out_func1");
      rchk(OFS_INIT_VIEW, 8'h00, "init_view");
      rchk(12'h000, 8'h00, "unmapped");
      // a new function waits for the configuration command
      wr(OFS_IN_FUNC0, IN_FAULT_CLR);
      lvl <= 7'h01;
      settle;
      chk("in_fn_deferred", 32'(in_fn_o), 32'(exp_fn(IN_FWD_RUN)));
      rchk(OFS_IN_FUNC0, IN_FAULT_CLR, "stored_copy");
      rchk(OFS_STATUS, 8'h02, "status_pend_c");
      foreach (in_codes[k]) begin
         wr(OFS_IN_FUNC0, in_codes[k]);
         cfg;
         chk("in_fn_code", 32'(in_fn_o), 32'(exp_fn(in_codes[k])));
      end
      rchk(OFS_STATUS, 8'h00, "status_applied");
      wr(OFS_IN_FUNC0, 8'h01);
      rchk(OFS_STATUS, 8'h08, "status_bad_code");
      rchk(OFS_IN_FUNC0, IN_FREE_REL, "kept_code");
      wr(OFS_IN_LOGIC0, 8'h02);
      rchk(OFS_STATUS, 8'h08, "status_bad_logic");
      // inversion on line 6 turns an idle line into an active brake release
      wr(OFS_IN_LOGIC0 + 12'h006, 8'h01);
      lvl <= 7'h00;
      settle;
      chk("in_inv_deferred", 32'(in_fn_o), 32'h0);
      cfg;
      chk("in_inv", 32'(in_fn_o), 32'(exp_fn(IN_BRAKE_REL)));
      foreach (out_codes[k]) begin
         wr(OFS_OUT_FUNC0, out_codes[k]);
         cfg;
         src <= iofpu_out_src_t'(out_oh[k]);
         settle;
         chk("out_sel", 32'(out_line_o[0]), 32'(out_codes[k] != 8'h00));
         src <= iofpu_out_src_t'(~out_oh[k]);
         settle;
         chk("out_others", 32'(out_line_o[0]), 32'h0);
      end
      src <= '0;
      wr(OFS_OUT_LOGIC0 + 12'h001, 8'h01);
      settle;
      chk("out_inv_deferred", 32'(out_line_o[1]), 32'h0);
      cfg;
      chk("out_inv", 32'(out_line_o[1]), 32'h1);
      // class A values act in the cycle after the write
      for (int v = 2; v >= 0; v--) begin
         wr(OFS_INIT_VIEW, 8'(v));
         #1;
         chk("view_now", 32'(panel_view_o), v);
      end
      wr(OFS_INIT_VIEW, 8'h01);
      wr(OFS_INIT_VIEW, 8'h03);
      #1;
      chk("view_refused", 32'(panel_view_o), 32'h1);
      wr(OFS_PANEL_EDIT, 8'h00);
      #1;
      chk("edit_now", 32'(panel_edit_o), 32'h0);
      @(posedge ref_clk_i);
      motor_run_i <= 1'b1;
      wr(OFS_B_SLOT, 8'h5A);
      settle;
      rchk(OFS_STATUS, 8'h01, "status_pend_b");
      @(posedge ref_clk_i);
      motor_run_i <= 1'b0;
      settle;
      rchk(OFS_STATUS, 8'h00, "status_b_done");
      rchk(OFS_B_SLOT, 8'h5A, "b_slot");
      // with the motor already stopped a class B value applies one cycle after the write, once its pending flag is set
      wr(OFS_B_SLOT, 8'h3C);
      settle;
      rchk(OFS_STATUS, 8'h00, "status_b_now");
      wr(OFS_D_SLOT, 8'hA5);
      rchk(OFS_STATUS, 8'h04, "status_pend_d");
      power_cycle(1'b0);
      rchk(OFS_D_SLOT, 8'hA5, "d_slot_kept");
      rchk(OFS_STATUS, 8'h00, "status_boot");
      rchk(OFS_IN_FUNC0, IN_FREE_REL, "func_kept");
      settle;
      chk("in_inv_boot", 32'(in_fn_o), 32'(exp_fn(IN_BRAKE_REL)));
      chk("view_boot", 32'(panel_view_o), 32'h1);
      chk("edit_boot", 32'(panel_edit_o), 32'h0);
      stop_test;
   end
endmodule
